// *** mpt_defines.vh ***
// Register offsets, field positions, reset values and widths of the timer.
`ifndef MPT_DEFINES_VH
`define MPT_DEFINES_VH

// ----------------------------------------------------------------
// Register word offsets (byte address divided by four)
// ----------------------------------------------------------------
`define MPT_REG_CTRL     6'h00
`define MPT_REG_PSC      6'h01
`define MPT_REG_ARR      6'h02
`define MPT_REG_CNT      6'h03
`define MPT_REG_CCMODE   6'h04
`define MPT_REG_DTG      6'h05
`define MPT_REG_CCR0     6'h06
`define MPT_REG_STATUS   6'h0A
`define MPT_REG_CLEAR    6'h0B
`define MPT_REG_IRQEN    6'h0C
`define MPT_REG_DMAEN    6'h0D

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define MPT_CTRL_EN      0
`define MPT_CTRL_DOWN    1
`define MPT_CTRL_CENTER  2
`define MPT_CTRL_OPM     3
`define MPT_CTRL_SMS_LO  4
`define MPT_CTRL_ENC     6
`define MPT_CTRL_HALL    7
`define MPT_CTRL_MOE     8
`define MPT_CTRL_W       9

// ----------------------------------------------------------------
// Slave modes and channel modes
// ----------------------------------------------------------------
`define MPT_SMS_OFF      2'h0
`define MPT_SMS_RESET    2'h1
`define MPT_SMS_GATED    2'h2
`define MPT_SMS_TRIGGER  2'h3
`define MPT_CM_TOGGLE    2'h0
`define MPT_CM_PWM       2'h1
`define MPT_CM_CAPTURE   2'h2
`define MPT_CM_PWM_INV   2'h3

// ----------------------------------------------------------------
// Event bit positions, reset values and widths
// ----------------------------------------------------------------
`define MPT_EV_UPD       0
`define MPT_EV_TRG       5
`define MPT_EV_W         6
`define MPT_CTRL_RST     9'h000
`define MPT_ARR_RST      32'hFFFF_FFFF
`define MPT_DT_W         8

`endif

// *** mpt_stage_model.sv ***
// Power stage, quadrature encoder and hall sensor model at the timer's pins.
`timescale 1ns/1ps

module mpt_stage_model (
	input wire         hclk,
	input wire [3:0]   ch_out,
	input wire [3:0]   ch_out_n,
	output logic [3:0] ch_in
);
	logic [1:0] ph;
	int         shorts;

	initial begin
		ch_in = 4'h0;
		ph = 2'h0;
		shorts = 0;
	end

	// shoot-through watch
	// Counts cycles in which both switches of one leg would conduct.
	always @(posedge hclk) begin
		if ((ch_out & ch_out_n) != 4'h0)
			shorts <= shorts + 1;
	end

	// quadrature step
	// One encoder step, A leading B forward; held long enough to be seen.
	task automatic step(input bit fwd);
		@(posedge hclk);
		ph = fwd ? ph + 2'h1 : ph - 2'h1;
		ch_in[1:0] <= {ph[1], ph[1] ^ ph[0]};
		repeat (4) @(posedge hclk);
	endtask

	// hall sensor levels
	// Sets the three sensor outputs at once, as a rotor position change does.
	task automatic hall(input logic [2:0] v);
		@(posedge hclk);
		ch_in[2:0] <= v;
		repeat (4) @(posedge hclk);
	endtask

	// Toggles one channel pin, as an external capture edge.
	task automatic pin(input int i);
		@(posedge hclk);
		ch_in[i] <= ~ch_in[i];
		repeat (4) @(posedge hclk);
	endtask
endmodule

// *** mpt_timer.v ***
// Capture/compare PWM timer unit with dead time, encoder, hall and link, on AHB-Lite.
//
// Contract
// [R1] Wide variant: 32-bit up/down reload counter.
// [R2] Narrow variant: 16-bit up/down reload counter.
// [R3] Four channels: capture, compare, PWM, one-pulse.
// [R4] Edge-aligned and center-aligned PWM counting.
// [R5] Complementary outputs with programmable dead time.
// [R6] Three-phase PWM over six outputs.
// [R7] PWM duty spans fully off to on.
// [R8] Timer link for sync and chaining.
// [R9] Independent DMA request generation.
// [R10] Quadrature encoder drives the counter.
// [R11] One to four hall sensors as inputs; code uses at most three, on channels 0 to 2.
// [R12] Reduced variant: 16-bit upcounter only.
// [R13] Reduced variant: one or two channels.
// [R14] Reduced variant syncs, or plain time base.
// [R15] Basic time base triggers converter, DMA.
// [R16] Prescaler divides by value plus one.
// [R17] Reload at limit raises update event.
`timescale 1ns/1ps
`include "mpt_defines.vh"

module mpt_timer #(
	parameter CNT_W   = 32,
	parameter NCH     = 4,
	parameter PSC_W   = 16,
	parameter UP_ONLY = 0
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             hsel,
	input  wire [31:0]      haddr,
	input  wire [1:0]       htrans,
	input  wire             hwrite,
	input  wire [2:0]       hsize,
	input  wire [31:0]      hwdata,
	input  wire             hready,
	output wire [31:0]      hrdata,
	output wire             hreadyout,
	output wire             hresp,
	input  wire [NCH-1:0]   ch_in,
	input  wire             trig_in,
	output wire [NCH-1:0]   ch_out,
	output wire [NCH-1:0]   ch_out_n,
	output wire             trig_out,
	output wire             dma_req,
	output wire             irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	reg  [31:0]            hrdata_q;
	reg                    hready_q;
	reg                    a_vld_q;
	reg                    a_wr_q;
	reg  [5:0]             a_idx_q;
	reg  [`MPT_CTRL_W-1:0] ctrl_q;
	reg  [PSC_W-1:0]       psc_q;
	reg  [PSC_W-1:0]       pdiv_q;
	reg  [CNT_W-1:0]       arr_q;
	reg  [CNT_W-1:0]       cnt_q;
	reg                    down_q;
	reg                    upd_q;
	reg  [4*NCH-1:0]       ccmode_q;
	reg  [`MPT_DT_W-1:0]   dtg_q;
	reg  [CNT_W-1:0]       ccr_q [0:NCH-1];
	reg  [`MPT_EV_W-1:0]   stat_q;
	reg  [`MPT_EV_W-1:0]   stat_d;
	reg  [`MPT_EV_W-1:0]   irqen_q;
	reg  [`MPT_EV_W-1:0]   dmaen_q;
	reg                    irq_q;
	reg                    dma_q;
	reg  [NCH-1:0]         cin_m_q;
	reg  [NCH-1:0]         cin_s_q;
	reg  [NCH-1:0]         cin_d_q;
	reg                    hall_d_q;
	reg                    trig_d_q;
	reg  [NCH-1:0]         out_q;
	reg  [NCH-1:0]         out_n_q;
	reg  [31:0]            rd_mux;
	wire [NCH-1:0]         cc_ev;
	wire [NCH-1:0]         cap_ev;
	wire [`MPT_EV_W-1:0]   ev;
	wire                   acc;
	wire                   bus_wr;
	wire                   psc_tick;
	wire                   run;
	wire                   cnt_tick;
	wire                   trig_rise;
	wire                   hall_x;
	wire                   hall_ev;
	wire                   enc_mode;
	wire                   enc_step;
	wire                   enc_up;
	wire                   center;
	wire                   cnt_down;
	wire [1:0]             sms;
	integer                k;
	integer                j;

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	// Address phase is taken when the slave is selected, htrans is NONSEQ or SEQ and the bus is ready.
	assign acc       = hsel & htrans[1] & hready;
	assign bus_wr    = a_vld_q & a_wr_q;
	assign hrdata    = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp     = 1'b0;

	// Latch the address phase; read data is fetched here so it stands in the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_vld_q  <= 1'b0;
			a_wr_q   <= 1'b0;
			a_idx_q  <= 6'h00;
			hrdata_q <= 32'h0000_0000;
			hready_q <= 1'b0;
		end else begin
			hready_q <= 1'b1;
			a_vld_q  <= acc;
			if (acc) begin
				a_wr_q  <= hwrite;
				a_idx_q <= haddr[7:2];
				if (!hwrite) begin
					hrdata_q <= rd_mux;
				end
			end
		end
	end

	// Read multiplexer; unmapped and write-only words read as zero.
	always @* begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:2])
			`MPT_REG_CTRL:   rd_mux[`MPT_CTRL_W-1:0] = ctrl_q;
			`MPT_REG_PSC:    rd_mux[PSC_W-1:0] = psc_q;
			`MPT_REG_ARR:    rd_mux[CNT_W-1:0] = arr_q;
			`MPT_REG_CNT:    rd_mux[CNT_W-1:0] = cnt_q;
			`MPT_REG_CCMODE: rd_mux[4*NCH-1:0] = ccmode_q;
			`MPT_REG_DTG:    rd_mux[`MPT_DT_W-1:0] = dtg_q;
			`MPT_REG_STATUS: rd_mux[`MPT_EV_W-1:0] = stat_q;
			`MPT_REG_IRQEN:  rd_mux[`MPT_EV_W-1:0] = irqen_q;
			`MPT_REG_DMAEN:  rd_mux[`MPT_EV_W-1:0] = dmaen_q;
			default: begin
				for (j = 0; j < NCH; j = j + 1) begin
					if (haddr[7:2] == `MPT_REG_CCR0 + j[5:0]) begin
						rd_mux[CNT_W-1:0] = ccr_q[j];
					end
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Input synchronisers and link trigger
	// ----------------------------------------------------------------
	// Channel pins pass two flops; a third stage keeps the previous value for edges.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cin_m_q  <= {NCH{1'b0}};
			cin_s_q  <= {NCH{1'b0}};
			cin_d_q  <= {NCH{1'b0}};
			hall_d_q <= 1'b0;
			trig_d_q <= 1'b0;
		end else begin
			cin_m_q  <= ch_in;
			cin_s_q  <= cin_m_q;
			cin_d_q  <= cin_s_q;
			hall_d_q <= hall_x;
			trig_d_q <= trig_in;
		end
	end

	// [R8] Trigger from a linked timer.
	assign trig_rise = trig_in & ~trig_d_q;
	assign sms       = ctrl_q[`MPT_CTRL_SMS_LO+1:`MPT_CTRL_SMS_LO];
	// [R11] Hall sensors combined by parity.
	assign hall_x    = ^cin_s_q[(NCH > 3 ? 2 : NCH-1):0];
	assign hall_ev   = ctrl_q[`MPT_CTRL_HALL] & (hall_x ^ hall_d_q);

	// [R10] Quadrature step and direction.
	assign enc_mode  = ctrl_q[`MPT_CTRL_ENC] & (NCH > 1) & (UP_ONLY == 0);
	assign enc_step  = enc_mode & ctrl_q[`MPT_CTRL_EN] &
		((cin_s_q[0] ^ cin_d_q[0]) | (cin_s_q[NCH > 1 ? 1 : 0] ^ cin_d_q[NCH > 1 ? 1 : 0]));
	assign enc_up    = cin_s_q[0] ^ cin_d_q[NCH > 1 ? 1 : 0];

	// ----------------------------------------------------------------
	// Prescaler and counter
	// ----------------------------------------------------------------

	// [R16] Divide the clock by prescale plus one.
	assign psc_tick = (pdiv_q >= psc_q);
	assign run      = ctrl_q[`MPT_CTRL_EN] & ~enc_mode &
		((sms != `MPT_SMS_GATED) | trig_in);
	assign cnt_tick = run & psc_tick;
	// [R12] Up-only variants ignore direction and center fields.
	assign center   = ctrl_q[`MPT_CTRL_CENTER] & (UP_ONLY == 0);
	assign cnt_down = center ? down_q : (ctrl_q[`MPT_CTRL_DOWN] & (UP_ONLY == 0));

	// Prescale divider; held at zero while the timer is stopped.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pdiv_q <= {PSC_W{1'b0}};
		end else if (!run || psc_tick) begin
			pdiv_q <= {PSC_W{1'b0}};
		end else begin
			pdiv_q <= pdiv_q + 1'b1;
		end
	end

	// [R1] [R2] Reloading up/down counter; width set by CNT_W.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q  <= {CNT_W{1'b0}};
			down_q <= 1'b0;
			upd_q  <= 1'b0;
		end else begin
			upd_q <= 1'b0;
			if (bus_wr && a_idx_q == `MPT_REG_CNT) begin
				cnt_q <= hwdata[CNT_W-1:0];
			end else if (sms == `MPT_SMS_RESET && trig_rise) begin
				// [R8] Linked reset restarts the count.
				cnt_q <= {CNT_W{1'b0}};
				upd_q <= 1'b1;
			end else if (enc_step) begin
				// [R10] Encoder position wraps within reload.
				if (enc_up) begin
					cnt_q <= (cnt_q >= arr_q) ? {CNT_W{1'b0}} : cnt_q + 1'b1;
				end else begin
					cnt_q <= (cnt_q == {CNT_W{1'b0}}) ? arr_q : cnt_q - 1'b1;
				end
			end else if (cnt_tick) begin
				// [R4] Center mode turns at both ends.
				if (center) begin
					if (!down_q && cnt_q >= arr_q) begin
						down_q <= 1'b1;
						upd_q  <= 1'b1;
						cnt_q  <= (arr_q == {CNT_W{1'b0}}) ? cnt_q : cnt_q - 1'b1;
					end else if (down_q && cnt_q == {CNT_W{1'b0}}) begin
						down_q <= 1'b0;
						upd_q  <= 1'b1;
						cnt_q  <= (arr_q == {CNT_W{1'b0}}) ? cnt_q : cnt_q + 1'b1;
					end else begin
						cnt_q <= down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
					end
				// [R17] Reload at limit and raise update.
				end else if (cnt_down) begin
					upd_q <= (cnt_q == {CNT_W{1'b0}});
					cnt_q <= (cnt_q == {CNT_W{1'b0}}) ? arr_q : cnt_q - 1'b1;
				end else begin
					upd_q <= (cnt_q >= arr_q);
					cnt_q <= (cnt_q >= arr_q) ? {CNT_W{1'b0}} : cnt_q + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Capture/compare channels
	// ----------------------------------------------------------------
	// [R13] Channel count set by NCH.
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
			wire [1:0]          cm    = ccmode_q[4*gi+1:4*gi];
			wire                pol   = ccmode_q[4*gi+2];
			// [R5] Complement pin enabled per channel.
			wire                cmp   = ccmode_q[4*gi+3];
			wire                match = (cnt_q == ccr_q[gi]);
			reg                 tog_q;
			reg                 ref_d_q;
			reg [`MPT_DT_W-1:0] dt_q;
			reg                 pwm_ref;
			reg [`MPT_DT_W-1:0] dt_nx;

			// [R3] Capture on rising pin; channel 0 also on hall change.
			assign cap_ev[gi] = (cm == `MPT_CM_CAPTURE) &
				((cin_s_q[gi] & ~cin_d_q[gi]) | ((gi == 0) & hall_ev));
			assign cc_ev[gi]  = cap_ev[gi] | ((cm != `MPT_CM_CAPTURE) & cnt_tick & match);

			// [R7] PWM reference: compare zero is off, above reload fully on.
			always @* begin
				case (cm)
					`MPT_CM_PWM:     pwm_ref = (cnt_q < ccr_q[gi]);
					`MPT_CM_PWM_INV: pwm_ref = ~(cnt_q < ccr_q[gi]);
					`MPT_CM_TOGGLE:  pwm_ref = tog_q;
					default:         pwm_ref = 1'b0;
				endcase
				// [R5] Dead time reloads on every reference edge.
				if (pwm_ref != ref_d_q && dtg_q != {`MPT_DT_W{1'b0}}) begin
					dt_nx = dtg_q;
				end else if (dt_q != {`MPT_DT_W{1'b0}}) begin
					dt_nx = dt_q - 1'b1;
				end else begin
					dt_nx = {`MPT_DT_W{1'b0}};
				end
			end

			// [R6] Each channel drives a main and complementary pin pair.
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					tog_q         <= 1'b0;
					ref_d_q       <= 1'b0;
					dt_q          <= {`MPT_DT_W{1'b0}};
					out_q[gi]     <= 1'b0;
					out_n_q[gi]   <= 1'b0;
				end else begin
					if (cm == `MPT_CM_TOGGLE && cnt_tick && match) begin
						tog_q <= ~tog_q;
					end
					ref_d_q     <= pwm_ref;
					dt_q        <= dt_nx;
					out_q[gi]   <= ctrl_q[`MPT_CTRL_MOE] & (cm != `MPT_CM_CAPTURE) &
						(pwm_ref ^ pol) & (~cmp | (dt_nx == {`MPT_DT_W{1'b0}}));
					out_n_q[gi] <= ctrl_q[`MPT_CTRL_MOE] & (cm != `MPT_CM_CAPTURE) &
						cmp & ~(pwm_ref ^ pol) & (dt_nx == {`MPT_DT_W{1'b0}});
				end
			end
		end
	endgenerate

	assign ch_out   = out_q;
	assign ch_out_n = out_n_q;
	// [R15] Update pulse doubles as converter and link trigger.
	assign trig_out = upd_q;

	// ----------------------------------------------------------------
	// Register file, events, interrupt and DMA
	// ----------------------------------------------------------------
	assign ev = {trig_rise, cc_ev, upd_q};

	// Sticky status: a new event wins over a clear in the same cycle.
	always @* begin
		stat_d = stat_q;
		if (bus_wr && a_idx_q == `MPT_REG_CLEAR) begin
			stat_d = stat_q & ~hwdata[`MPT_EV_W-1:0];
		end
		stat_d = stat_d | ev;
	end

	// Software-written registers, captures and one-pulse stop.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q   <= `MPT_CTRL_RST;
			psc_q    <= {PSC_W{1'b0}};
			arr_q    <= `MPT_ARR_RST;
			ccmode_q <= {4*NCH{1'b0}};
			dtg_q    <= {`MPT_DT_W{1'b0}};
			stat_q   <= {`MPT_EV_W{1'b0}};
			irqen_q  <= {`MPT_EV_W{1'b0}};
			dmaen_q  <= {`MPT_EV_W{1'b0}};
			irq_q    <= 1'b0;
			dma_q    <= 1'b0;
			for (k = 0; k < NCH; k = k + 1) begin
				ccr_q[k] <= {CNT_W{1'b0}};
			end
		end else begin
			stat_q <= stat_d;
			irq_q  <= |(stat_d & irqen_q);
			// [R9] DMA request pulses on an enabled event.
			dma_q  <= |(ev & dmaen_q);
			if (bus_wr) begin
				case (a_idx_q)
					`MPT_REG_CTRL:   ctrl_q   <= hwdata[`MPT_CTRL_W-1:0];
					`MPT_REG_PSC:    psc_q    <= hwdata[PSC_W-1:0];
					`MPT_REG_ARR:    arr_q    <= hwdata[CNT_W-1:0];
					`MPT_REG_CCMODE: ccmode_q <= hwdata[4*NCH-1:0];
					`MPT_REG_DTG:    dtg_q    <= hwdata[`MPT_DT_W-1:0];
					`MPT_REG_IRQEN:  irqen_q  <= hwdata[`MPT_EV_W-1:0];
					`MPT_REG_DMAEN:  dmaen_q  <= hwdata[`MPT_EV_W-1:0];
					default: begin
						for (k = 0; k < NCH; k = k + 1) begin
							if (a_idx_q == `MPT_REG_CCR0 + k[5:0]) begin
								ccr_q[k] <= hwdata[CNT_W-1:0];
							end
						end
					end
				endcase
			end
			// [R14] Linked trigger starts a stopped timer.
			if (sms == `MPT_SMS_TRIGGER && trig_rise) begin
				ctrl_q[`MPT_CTRL_EN] <= 1'b1;
			end
			// [R3] One-pulse mode stops at the update.
			if (ctrl_q[`MPT_CTRL_OPM] && upd_q) begin
				ctrl_q[`MPT_CTRL_EN] <= 1'b0;
			end
			// [R3] Captured count lands in the compare register.
			for (k = 0; k < NCH; k = k + 1) begin
				if (cap_ev[k]) begin
					ccr_q[k] <= cnt_q;
				end
			end
		end
	end

	assign irq     = irq_q;
	assign dma_req = dma_q;

endmodule

// *** mpt_timer_sva.sv ***
// Concurrent checks on the bus and pin ports of the timer unit.
`timescale 1ns/1ps

module mpt_timer_sva #(
	parameter NCH = 4
) (
	input wire           hclk,
	input wire           hresetn,
	input wire           hsel,
	input wire [1:0]     htrans,
	input wire           hwrite,
	input wire           hready,
	input wire [31:0]    hrdata,
	input wire           hreadyout,
	input wire           hresp,
	input wire [NCH-1:0] ch_out,
	input wire [NCH-1:0] ch_out_n,
	input wire           trig_out,
	input wire           dma_req,
	input wire           irq
);
	// Transfers that the slave takes at a rising edge.
	wire wr_take = hsel & htrans[1] & hready & hwrite;
	wire rd_take = hsel & htrans[1] & hready & ~hwrite;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_update_one_shot: assert property (trig_out |=> !trig_out)
		else $error("update pulse longer than one cycle");
	chk_dma_one_shot: assert property (dma_req |=> !dma_req)
		else $error("dma request longer than one cycle");
	chk_leg_no_short: assert property ((ch_out & ch_out_n) == '0)
		else $error("both outputs of a pair high");
	chk_reset_quiet: assert property ($rose(hresetn) |-> ch_out == '0 && !irq && !trig_out)
		else $error("outputs active straight after reset");
	chk_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_take, 1) || $past(wr_take, 2)
		|| $past(wr_take, 3) || $past(wr_take, 4))
		else $error("interrupt dropped without a register write");
	chk_rdata_hold: assert property ($past(hresetn) && !$past(rd_take) |-> $stable(hrdata))
		else $error("read data changed without a read");
	chk_ready_no_wait: assert property ($past(hresetn) |-> hreadyout)
		else $error("slave inserted a wait state");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("slave response not okay");

	cover_update: cover property (trig_out);
	cover_irq: cover property ($rose(irq));
	cover_dma: cover property (dma_req);
	cover_comp: cover property (ch_out_n[0]);
endmodule

// *** tb.sv ***
// Self-checking bench for the timer unit: bus tasks, PWM, events, capture, encoder.
`timescale 1ns/1ps
`include "mpt_defines.vh"

module tb;
	logic        hclk, hresetn, hsel, hwrite, trig_in;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, trig_out, dma_req, irq;
	wire  [3:0]  ch_in, ch_out, ch_out_n;
	int          mismatches, n_compared, np, nh, nn, nd;
	int          cc[3] = '{0, 3, 10};
	int          hi[3] = '{0, 6, 20};

	mpt_timer dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch_in(ch_in),
		.trig_in(trig_in), .ch_out(ch_out), .ch_out_n(ch_out_n), .trig_out(trig_out),
		.dma_req(dma_req), .irq(irq)
	);

	mpt_stage_model pm (.hclk(hclk), .ch_out(ch_out), .ch_out_n(ch_out_n), .ch_in(ch_in));

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	// One single word transfer; the data phase is held until ready is seen.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic rchk(input logic [5:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
	endtask

	// Syncs to an update pulse, then counts pulses and output highs over n cycles.
	task automatic meas(input int n);
		np = 0;
		nh = 0;
		nn = 0;
		nd = 0;
		do @(posedge hclk); while (trig_out !== 1'b1);
		repeat (n) begin
			@(posedge hclk);
			np += (trig_out === 1'b1);
			nh += (ch_out[0] === 1'b1);
			nn += (ch_out_n[0] === 1'b1);
			nd += (dma_req === 1'b1);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	// Free running 200 MHz clock.
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// Cuts a hang short well after the tests should have ended.
	initial begin
		#200000;
		mismatches++;
		$display("wrong value at %0t: watchdog expired", $time);
		end_sim;
	end

	// Main sequence of tests.
	initial begin
		mismatches = 0;
		n_compared = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'b010;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		trig_in = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk(`MPT_REG_CTRL, 32'h0000_0000, "control reset");
		rchk(`MPT_REG_ARR, `MPT_ARR_RST, "reload reset");
		rchk(`MPT_REG_PSC, 32'h0000_0000, "prescaler reset");
		rchk(6'h3F, 32'h0000_0000, "unmapped read");
		$display("test reset values done");
		wr(`MPT_REG_ARR, 32'h0000_0009);
		wr(`MPT_REG_CCMODE, 32'h0000_0001);
		wr(`MPT_REG_DMAEN, 32'h0000_0001);
		wr(`MPT_REG_CTRL, 32'h0000_0101);
		for (int i = 0; i < 3; i++) begin
			wr(`MPT_REG_CCR0, cc[i]);
			meas(20);
			chk(nh, hi[i], "pwm duty");
			chk(np, 2, "edge period");
			chk(nd, 2, "dma requests");
		end
		for (int p = 1; p < 3; p++) begin
			wr(`MPT_REG_PSC, p);
			meas(60);
			chk(np, 6 / (p + 1), "prescaled period");
		end
		wr(`MPT_REG_PSC, 32'h0000_0000);
		wr(`MPT_REG_CTRL, 32'h0000_0103);
		meas(20);
		chk(np, 2, "down period");
		wr(`MPT_REG_CTRL, 32'h0000_0105);
		meas(18);
		chk(np, 2, "center updates");
		$display("test pwm and prescaler done");
		rchk(`MPT_REG_STATUS, 32'h0000_001F, "event flags");
		repeat (3) @(posedge hclk);
		chk(irq, 1'b0, "masked interrupt");
		wr(`MPT_REG_IRQEN, 32'h0000_0001);
		repeat (3) @(posedge hclk);
		chk(irq, 1'b1, "enabled interrupt");
		wr(`MPT_REG_CTRL, 32'h0000_0000);
		wr(`MPT_REG_CLEAR, 32'h0000_003F);
		rchk(`MPT_REG_STATUS, 32'h0000_0000, "cleared flags");
		repeat (3) @(posedge hclk);
		chk(irq, 1'b0, "cleared interrupt");
		$display("test interrupt done");
		wr(`MPT_REG_CCMODE, 32'h0000_0020);
		wr(`MPT_REG_CTRL, 32'h0000_0001);
		wr(`MPT_REG_CLEAR, 32'h0000_003F);
		pm.pin(1);
		bus(1'b0, `MPT_REG_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0004, 32'h0000_0004, "capture flag");
		wr(`MPT_REG_CCMODE, 32'h0000_0002);
		wr(`MPT_REG_CTRL, 32'h0000_0081);
		wr(`MPT_REG_CLEAR, 32'h0000_003F);
		pm.hall(3'b110);
		bus(1'b0, `MPT_REG_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0002, 32'h0000_0002, "hall capture");
		pm.hall(3'b000);
		$display("test capture done");
		wr(`MPT_REG_CCMODE, 32'h0000_0000);
		wr(`MPT_REG_ARR, 32'h0000_0063);
		wr(`MPT_REG_CTRL, 32'h0000_0041);
		wr(`MPT_REG_CNT, 32'h0000_0000);
		repeat (4) pm.step(1'b1);
		rchk(`MPT_REG_CNT, 32'h0000_0004, "encoder forward");
		repeat (2) pm.step(1'b0);
		rchk(`MPT_REG_CNT, 32'h0000_0002, "encoder back");
		$display("test encoder done");
		wr(`MPT_REG_CTRL, 32'h0000_0000);
		wr(`MPT_REG_ARR, 32'h0000_0009);
		wr(`MPT_REG_CCR0, 32'h0000_0005);
		wr(`MPT_REG_CCMODE, 32'h0000_0009);
		wr(`MPT_REG_DTG, 32'h0000_0002);
		wr(`MPT_REG_CTRL, 32'h0000_0101);
		meas(20);
		chk(nh, 6, "main with dead time");
		chk(nn, 6, "complement with dead time");
		chk(pm.shorts, 0, "leg overlap");
		$display("test dead time done");
		wr(`MPT_REG_CTRL, 32'h0000_0038);
		wr(`MPT_REG_CLEAR, 32'h0000_003F);
		trig_in <= 1'b1;
		repeat (2) @(posedge hclk);
		trig_in <= 1'b0;
		repeat (15) @(posedge hclk);
		bus(1'b0, `MPT_REG_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0021, 32'h0000_0021, "triggered start");
		rchk(`MPT_REG_CTRL, 32'h0000_0038, "one pulse stop");
		$display("test link trigger done");
		end_sim;
	end
endmodule

bind mpt_timer mpt_timer_sva #(.NCH(NCH)) u_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.ch_out(ch_out), .ch_out_n(ch_out_n), .trig_out(trig_out), .dma_req(dma_req), .irq(irq)
);
